// File: logic/hifs_supervisor.sv
// Fault supervisor for a two-channel two-wire Hall interface.
// Assumes comparator outputs and the select pin are asynchronous.
`timescale 1ns/1ns
`include "hifs_map.svh"
module hifs_supervisor #(
   parameter int BLANK_CYC = `HIFS_BLANK_CYC   // Blanking length in cycles
) (
   input  wire logic       core_clk,              // Core clock, 20 MHz
   input  wire logic       srst,                  // Synchronous reset, high
   input  wire logic       clk_en,                // Clock enable
   input  wire logic       supply_fault,          // Supply out of 6V..18V
   input  wire logic [1:0] open_fault,            // Channel current below 2mA
   input  wire logic [1:0] short_supply_fault,    // Channel above supply
   input  wire logic [1:0] short_ground_fault,    // Channel current above 23mA
   input  wire logic       fault_report_select,   // Select pin, falling edge restarts
   output logic            fault_n,               // Fault flag, low active
   output logic [1:0]      sensor_power_en,       // Normal sensor current
   output logic [1:0]      pullup_en,             // 50uA pull-up source
   output logic [1:0]      blanking               // Channel in blanking
);
   // -----------------------------------------------------------------
   // Input synchronisers
   // -----------------------------------------------------------------
   localparam int NIN = 8;              // Synchronised input bits
   logic [NIN-1:0] raw;                 // Raw asynchronous inputs
   logic [NIN-1:0] s1, s2, s3;          // Three stage chain
   logic [NIN-1:0] filt;                // Accepted levels
   logic [NIN-1:0] next_filt;           // Next accepted levels

   assign raw = {fault_report_select, short_ground_fault, short_supply_fault,
                 open_fault, supply_fault};

   // Accept a change only when stages two and three agree
   always_comb
   begin
      for (int i = 0; i < NIN; i++)
      begin
         next_filt[i] = (s2[i] == s3[i]) ? s2[i] : filt[i];   // [RL9]
      end
   end

   // Register chain; s1 feeds s2 only
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         s1   <= '0;
         s2   <= '0;
         s3   <= '0;
         filt <= '0;
      end
      else if (clk_en)
      begin
         s1   <= raw;
         s2   <= s1;
         s3   <= s2;
         filt <= next_filt;
      end
   end

   logic       sup_f;     // Supply fault
   logic [1:0] opn_f;     // Open faults
   logic [1:0] ssp_f;     // Short to supply faults
   logic [1:0] sgn_f;     // Short to ground faults
   logic       sel;       // Select level
   logic       sel_q;     // Previous select level
   logic       sel_fall;  // Falling edge pulse

   assign sup_f = filt[0];
   assign opn_f = filt[2:1];
   assign ssp_f = filt[4:3];
   assign sgn_f = filt[6:5];
   assign sel   = filt[7];
   assign sel_fall = sel_q & ~sel;   // [RL7]

   // Edge detector on the filtered select
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         sel_q <= 1'b0;
      end
      else if (clk_en)
      begin
         sel_q <= sel;
      end
   end

   // -----------------------------------------------------------------
   // Per-channel state machines
   // -----------------------------------------------------------------
   hifs_pkg::hifs_state_t st      [`HIFS_NCH];   // Channel state
   hifs_pkg::hifs_state_t next_st [`HIFS_NCH];   // Next channel state
   logic [1:0] fault_now;                         // Channel reports fault

   // A non-latched fault on a channel
   function automatic logic soft_fault(input logic o, input logic s);
      soft_fault = o | s;
   endfunction : soft_fault

   genvar g;
   generate
      for (g = 0; g < `HIFS_NCH; g++)
      begin : g_ch
         hifs_blank_if bl ();   // Counter link

         hifs_blank_cnt #(
            .BLANK_CYC (BLANK_CYC)
         ) u_cnt (
            .core_clk (core_clk),
            .srst     (srst),
            .clk_en   (clk_en),
            .bl       (bl)
         );

         // Next state; supply fault dominates everything
         always_comb
         begin
            next_st[g] = st[g];
            unique case (st[g])
               hifs_pkg::HIFS_OFF:
               begin
                  // Restart once every soft fault is gone
                  if (!sup_f && !soft_fault(opn_f[g], ssp_f[g]))
                  begin
                     next_st[g] = hifs_pkg::HIFS_BLANK;   // [RL2] [RL4] [RL8]
                  end
               end
               hifs_pkg::HIFS_BLANK, hifs_pkg::HIFS_RUN:
               begin
                  if (sup_f)
                  begin
                     next_st[g] = hifs_pkg::HIFS_OFF;   // [RL1]
                  end
                  else if (sgn_f[g])
                  begin
                     next_st[g] = hifs_pkg::HIFS_GND;   // [RL6]
                  end
                  else if (soft_fault(opn_f[g], ssp_f[g]))
                  begin
                     next_st[g] = hifs_pkg::HIFS_OFF;   // [RL3] [RL5]
                  end
                  else if (st[g] == hifs_pkg::HIFS_BLANK && bl.done)
                  begin
                     next_st[g] = hifs_pkg::HIFS_RUN;
                  end
               end
               hifs_pkg::HIFS_GND:
               begin
                  // Held; the select edge, supply loss or an open input ends it
                  if (sup_f)
                  begin
                     next_st[g] = hifs_pkg::HIFS_OFF;   // [RL1]
                  end
                  else if (sel_fall)
                  begin
                     next_st[g] = hifs_pkg::HIFS_BLANK;   // [RL7]
                  end
                  else if (opn_f[g])
                  begin
                     // Unloaded pull-up shows open; reconnect restarts later
                     next_st[g] = hifs_pkg::HIFS_OFF;   // [RL8]
                  end
               end
            endcase
         end

         // Load the counter on every entry to blanking
         assign bl.start = (next_st[g] == hifs_pkg::HIFS_BLANK) &&
                           (st[g] != hifs_pkg::HIFS_BLANK) && clk_en;

         // Register only
         always_ff @(posedge core_clk)
         begin
            if (srst)
            begin
               st[g] <= hifs_pkg::HIFS_OFF;
            end
            else if (clk_en)
            begin
               st[g] <= next_st[g];
            end
         end

         assign fault_now[g] = (st[g] != hifs_pkg::HIFS_RUN);
      end
   endgenerate

   // -----------------------------------------------------------------
   // Registered outputs
   // -----------------------------------------------------------------
   logic       next_fault_n;   // Next flag
   logic [1:0] next_pwr;       // Next power enables
   logic [1:0] next_pu;        // Next pull-up enables
   logic [1:0] next_blk;       // Next blanking

   // Outputs follow next state so they lag the state by nothing
   always_comb
   begin
      next_fault_n = 1'b1;
      for (int i = 0; i < `HIFS_NCH; i++)
      begin
         next_pwr[i] = (next_st[i] == hifs_pkg::HIFS_BLANK) ||
                       (next_st[i] == hifs_pkg::HIFS_RUN);   // [RL1] [RL3] [RL5]
         next_pu[i]  = (next_st[i] == hifs_pkg::HIFS_GND);   // [RL6]
         next_blk[i] = (next_st[i] == hifs_pkg::HIFS_BLANK);
         if (next_st[i] != hifs_pkg::HIFS_RUN)
         begin
            next_fault_n = 1'b0;   // [RL1] [RL3] [RL5] [RL6] [RL8]
         end
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         fault_n         <= 1'b0;
         sensor_power_en <= 2'h0;
         pullup_en       <= 2'h0;
         blanking        <= 2'h0;
      end
      else if (clk_en)
      begin
         fault_n         <= next_fault_n;
         sensor_power_en <= next_pwr;
         pullup_en       <= next_pu;
         blanking        <= next_blk;
      end
   end
endmodule : hifs_supervisor

// File: inc/hifs_map.svh
// Constants of the Hall input fault supervisor: timing counts, channel count and reset values.
// Assumes a 20 MHz core clock; included by its bare name.
//
// Overview of operation
// RL1 - Supply out of range: flag low, both off
// RL2 - Supply back: restart both with blanking
// RL3 - Open channel: flag low, cut that channel
// RL4 - Open channel reloaded: restart with blanking
// RL5 - Short to supply: flag low, cut channel
// RL6 - Short to ground: hold, pull-up only
// RL7 - Falling select edge restarts grounded channels
// RL8 - Only short to ground is held
// RL9 - Synchronise fault inputs, count blanking cycles
`ifndef HIFS_MAP_SVH
`define HIFS_MAP_SVH

// -----------------------------------------------------------------
// Timing
// -----------------------------------------------------------------
`define HIFS_CLK_HZ       20000000
`define HIFS_BLANK_US     100   // Plain default; tune to the sensors in use
`define HIFS_BLANK_CYC    ((`HIFS_BLANK_US * `HIFS_CLK_HZ + 999999) / 1000000)
`define HIFS_CNT_W        12

// -----------------------------------------------------------------
// Channel count and reset values
// -----------------------------------------------------------------
`define HIFS_NCH          2
`define HIFS_SYNC_RST     3'h0

`endif

// File: inc/hifs_pkg.sv
// Types of the Hall input fault supervisor.
// Assumes nothing beyond a SystemVerilog compiler.
package hifs_pkg;
   // Per-channel supervision state
   typedef enum logic [1:0] {
      HIFS_OFF   = 2'b00,   // Current removed
      HIFS_BLANK = 2'b01,   // Restart blanking
      HIFS_RUN   = 2'b10,   // Normal reporting
      HIFS_GND   = 2'b11    // Held short to ground
   } hifs_state_t;
endpackage : hifs_pkg

// File: inc/hifs_blank_if.sv
// Interface between the supervisor and its blanking counter.
// Assumes a single clock domain.
`timescale 1ns/1ns
interface hifs_blank_if;
   logic start;   // Load counter, one-cycle pulse
   logic done;    // Count expired, one-cycle pulse
   modport sup (output start, input done);
   modport cnt (input start, output done);
endinterface : hifs_blank_if

// File: logic/hifs_blank_cnt.sv
// Blanking cycle counter for one channel.
// Assumes start pulses come from the supervisor on the same clock.
`timescale 1ns/1ns
`include "hifs_map.svh"
module hifs_blank_cnt #(
   parameter int BLANK_CYC = `HIFS_BLANK_CYC   // Blanking length in cycles
) (
   input  wire logic   core_clk,   // Core clock
   input  wire logic   srst,       // Synchronous reset
   input  wire logic   clk_en,     // Freezes state when low
   hifs_blank_if.cnt   bl          // Start and done
);
   logic [`HIFS_CNT_W-1:0] cnt;        // Remaining cycles
   logic [`HIFS_CNT_W-1:0] next_cnt;   // Next count
   logic                   next_done;  // Next done pulse
   logic                   done_q;     // Registered done

   // -----------------------------------------------------------------
   // Next count
   // -----------------------------------------------------------------
   always_comb
   begin
      next_cnt  = cnt;
      next_done = 1'b0;
      if (bl.start)
      begin
         next_cnt = BLANK_CYC[`HIFS_CNT_W-1:0];   // [RL9]
      end
      else if (cnt != '0)
      begin
         next_cnt  = cnt - 1'b1;
         next_done = (cnt == {{(`HIFS_CNT_W-1){1'b0}}, 1'b1});
      end
   end

   // Register only
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         cnt    <= '0;
         done_q <= 1'b0;
      end
      else if (clk_en)
      begin
         cnt    <= next_cnt;
         done_q <= next_done;
      end
   end

   assign bl.done = done_q & clk_en;
endmodule : hifs_blank_cnt

// File: tb/hifs_supervisor_properties.sv
// Port checker for the Hall fault supervisor.
// Assumes the bench keeps clk_en high while traffic runs.
`timescale 1ns/1ns
module hifs_supervisor_properties #(
   parameter int BLANK_CYC = 8                   // Blanking length
) (
   input wire logic       core_clk,              // Clock
   input wire logic       srst,                  // Reset
   input wire logic       clk_en,                // Enable
   input wire logic       supply_fault,          // Supply bad
   input wire logic [1:0] open_fault,            // Open
   input wire logic [1:0] short_supply_fault,    // To supply
   input wire logic [1:0] short_ground_fault,    // To ground
   input wire logic       fault_report_select,   // Select pin
   input wire logic       fault_n,               // Flag
   input wire logic [1:0] sensor_power_en,       // Power
   input wire logic [1:0] pullup_en,             // Pull-up
   input wire logic [1:0] blanking               // Blanking
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (srst || !clk_en);
   // Channel a fully off, and channel a free of every fault
   sequence s_off_a;
      !sensor_power_en[0] && !pullup_en[0];
   endsequence
   sequence s_calm_a;
      !supply_fault && !open_fault[0] && !short_supply_fault[0] && !short_ground_fault[0];
   endsequence
   // Ground short seen while nothing stronger dominates
   sequence s_gnd_a;
      (short_ground_fault[0] && !supply_fault && !open_fault[0])[*4];
   endsequence
   property p_sup;
      supply_fault[*5] |=> !fault_n && sensor_power_en == 2'h0;
   endproperty
   property p_open;
      open_fault[0][*5] |=> !fault_n && !sensor_power_en[0];
   endproperty
   property p_ssup;
      short_supply_fault[1][*5] |=> !fault_n && !sensor_power_en[1];
   endproperty
   property p_gnd;
      s_gnd_a |-> ##[1:2] (pullup_en[0] && !sensor_power_en[0]);
   endproperty
   // Hold survives as long as no select edge, no open input and no supply fault
   property p_held;
      (pullup_en[0] && !open_fault[0] && !supply_fault && $stable(fault_report_select))[*5]
      |=> pullup_en[0];
   endproperty
   property p_run;
      fault_n |-> sensor_power_en == 2'h3 && blanking == 2'h0 && pullup_en == 2'h0;
   endproperty
   property p_blank_min;
      $fell(blanking[0]) && sensor_power_en[0] |-> $past(blanking[0], BLANK_CYC - 1);
   endproperty
   property p_blank_end;
      $rose(blanking[1]) |-> ##[1:12] !blanking[1];
   endproperty
   property p_restart;
      s_off_a ##1 s_calm_a[*6] |-> blanking[0];
   endproperty
   a_sup:       assert property (p_sup) else $error("supply fault not handled");
   a_open:      assert property (p_open) else $error("open not cut");
   a_ssup:      assert property (p_ssup) else $error("supply short not cut");
   a_gnd:       assert property (p_gnd) else $error("ground short not held");
   a_held:      assert property (p_held) else $error("hold lost");
   a_run:       assert property (p_run) else $error("flag high while not running");
   a_blank_min: assert property (p_blank_min) else $error("blanking too short");
   a_blank_end: assert property (p_blank_end) else $error("blanking too long");
   a_restart:   assert property (p_restart) else $error("no restart");
endmodule : hifs_supervisor_properties
bind hifs_supervisor hifs_supervisor_properties #(.BLANK_CYC(BLANK_CYC)) chk_i (
   .core_clk, .srst, .clk_en, .supply_fault, .open_fault, .short_supply_fault,
   .short_ground_fault, .fault_report_select, .fault_n, .sensor_power_en,
   .pullup_en, .blanking);

// File: tb/hifs_sensor_model.sv
// Far side: two Hall sensors, their wiring and the supply comparator.
// Assumes load codes 0 ok, 1 open, 2 to supply, 3 to ground.
`timescale 1ns/1ns
module hifs_sensor_model (
   input  wire logic [3:0] load,                 // Two bits per channel
   input  wire logic       vbat_bad,             // Supply out of range
   input  wire logic [1:0] power_en,             // Normal current on
   output logic            supply_fault,         // Supply comparator
   output logic [1:0]      open_fault,           // Current too low
   output logic [1:0]      short_supply_fault,   // Input above supply
   output logic [1:0]      short_ground_fault    // Current too high
);
   // A ground short draws current only while powered, so no kind latch here
   always_comb
   begin
      supply_fault = vbat_bad;
      for (int c = 0; c < 2; c++)
      begin
         open_fault[c]         = load[2*c +: 2] == 2'h1;
         short_supply_fault[c] = load[2*c +: 2] == 2'h2;
         short_ground_fault[c] = load[2*c +: 2] == 2'h3 && power_en[c];
      end
   end
endmodule : hifs_sensor_model

// File: tb/hifs_supervisor_bench.sv
// Bench for the Hall fault supervisor with a sensor model.
// Assumes 50 ns clock and a short blanking count.
`timescale 1ns/1ns
module hifs_supervisor_bench;
   localparam int BLK = 8;                  // Short blanking for sim
   logic       core_clk;                    // Clock
   logic       srst;                        // Reset
   logic       clk_en;                      // Clock enable
   logic       sel;                         // Select pin
   logic       vbat_bad;                    // Supply bad
   logic [3:0] load;                        // Wiring per channel
   logic       supply_fault;                // Model outputs
   logic [1:0] open_fault;
   logic [1:0] short_supply_fault;
   logic [1:0] short_ground_fault;
   logic       fault_n;                     // Design outputs
   logic [1:0] sensor_power_en;
   logic [1:0] pullup_en;
   logic [1:0] blanking;
   int         bad_count;                   // Mismatches
   int         samples_checked;             // Comparisons
   int         cyc;                         // Timeout count
   hifs_sensor_model hifs_sensor_model_i (.load(load), .vbat_bad(vbat_bad),
      .power_en(sensor_power_en), .supply_fault(supply_fault), .open_fault(open_fault),
      .short_supply_fault(short_supply_fault), .short_ground_fault(short_ground_fault));
   hifs_supervisor #(.BLANK_CYC(BLK)) hifs_supervisor_i (.core_clk(core_clk), .srst(srst),
      .clk_en(clk_en), .supply_fault(supply_fault), .open_fault(open_fault),
      .short_supply_fault(short_supply_fault), .short_ground_fault(short_ground_fault),
      .fault_report_select(sel), .fault_n(fault_n), .sensor_power_en(sensor_power_en),
      .pullup_en(pullup_en), .blanking(blanking));
   task automatic chk(input string nm, input logic [1:0] exp, input logic [1:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         bad_count++;
         $display("unexpected %s exp %h got %h", nm, exp, got);
      end
   endtask : chk
   // Let edges pass, then sample after their updates landed
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : tick
   task automatic summarize;
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : summarize
   task automatic t_supply;
      @(posedge core_clk) vbat_bad <= 1'b1;
      tick(6);
      chk("flag", 2'h0, fault_n);
      chk("power", 2'h0, sensor_power_en);
      @(posedge core_clk) vbat_bad <= 1'b0;
      tick(6);
      chk("blank", 2'h3, blanking);
      tick(BLK + 2);
      chk("flag", 2'h1, fault_n);
      $display("supply test done");
   endtask : t_supply
   // Soft fault on one channel: the other channel keeps its current
   task automatic t_soft(input logic [3:0] cond, input logic [1:0] pw);
      @(posedge core_clk) load <= cond;
      tick(6);
      chk("power", pw, sensor_power_en);
      chk("flag", 2'h0, fault_n);
      @(posedge core_clk) load <= 4'h0;
      tick(6);
      chk("blank", ~pw, blanking);
      tick(BLK + 2);
      chk("flag", 2'h1, fault_n);
      $display("soft fault test done");
   endtask : t_soft
   task automatic t_ground;
      @(posedge core_clk) load <= 4'h3;
      tick(6);
      chk("pullup", 2'h1, pullup_en);
      chk("power", 2'h2, sensor_power_en);
      @(posedge core_clk) load <= 4'h0;
      tick(20);
      chk("pullup", 2'h1, pullup_en);
      @(posedge core_clk) sel <= 1'b0;
      tick(6);
      chk("blank", 2'h1, blanking);
      @(posedge core_clk) sel <= 1'b1;
      tick(BLK + 2);
      chk("power", 2'h3, sensor_power_en);
      @(posedge core_clk) sel <= 1'b0;
      tick(6);
      chk("blank", 2'h0, blanking);
      $display("ground test done");
   endtask : t_ground
   // Manual re-energize: open a held channel, then reconnect it
   task automatic t_manual;
      @(posedge core_clk) load <= 4'h3;
      tick(6);
      chk("pullup", 2'h1, pullup_en);
      @(posedge core_clk) load <= 4'h1;
      tick(6);
      chk("pullup", 2'h0, pullup_en);
      chk("power", 2'h2, sensor_power_en);
      @(posedge core_clk) load <= 4'h0;
      tick(6);
      chk("blank", 2'h1, blanking);
      tick(BLK + 2);
      chk("flag", 2'h1, fault_n);
      $display("manual restart test done");
   endtask : t_manual
   // Freeze in blanking: the count must not move while clk_en is low
   task automatic t_freeze;
      @(posedge core_clk) load <= 4'h1;
      tick(6);
      @(posedge core_clk) load <= 4'h0;
      tick(6);
      @(posedge core_clk) clk_en <= 1'b0;
      tick(3 * BLK);
      chk("blank", 2'h1, blanking);
      chk("power", 2'h3, sensor_power_en);
      @(posedge core_clk) clk_en <= 1'b1;
      tick(BLK + 2);
      chk("flag", 2'h1, fault_n);
      $display("freeze test done");
   endtask : t_freeze
   initial
   begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   // Hang guard: far beyond the few hundred cycles the tests take
   always @(posedge core_clk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         bad_count++;
         summarize();
      end
   end
   initial
   begin
      srst = 1'b1;
      clk_en = 1'b1;
      sel = 1'b1;
      vbat_bad = 1'b0;
      load = 4'h0;
      repeat (8) @(posedge core_clk);
      srst <= 1'b0;
      tick(6);
      chk("blank", 2'h3, blanking);
      tick(BLK + 2);
      chk("flag", 2'h1, fault_n);
      $display("reset test done");
      t_supply();
      t_soft(4'h1, 2'h2);
      t_soft(4'h8, 2'h1);
      t_ground();
      t_manual();
      t_freeze();
      summarize();
   end
endmodule : hifs_supervisor_bench
